//--- design/ofd_decoder.sv
// Contract
// - Access select 0 addresses the access bank, bank register ignored.
// - Access select 1 takes the bank number from the bank register.
// - Three-bit bit index picks bit 0 to 7 of a file register.
// - Destination 0 writes the accumulator, 1 writes the file register.
// - Short operand is 8-bit file address or 2-bit pointer select.
// - Register move first word carries 12-bit source address.
// - Register move second word carries 12-bit destination address.
// - Literals extracted as 8, 12 or 20 bit constants by format.
// - Table step select: none, post-increment, post-decrement, pre-increment.
// - Branch operand relative two's complement, or absolute for call/goto/return.
// - Fast select 1 saves or restores shadow copies; 0 leaves them.
// - Table pointer is 21 bits; transfers go through 8-bit latch.
// - Don't-care opcode bits are ignored; tools emit them as zero.
// - Indexed moves use 7-bit source and destination offsets.
// - Five result flags kept: carry, digit carry, zero, wrap, negative.
// - Multiply product split into high and low byte registers.
// - Second words carry ones in top four bits; alone they are no-ops.
// - One instruction cycle spans four oscillator periods.
// - One cycle normally; two on true skip or program counter change.
//
// The implementer's own choices: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none

module ofd_decoder
    import ofd_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o
);

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_EXEC = 2'b10
    } ofd_state_e;

    typedef struct packed {
        ofd_state_e state;
        logic wait_r;
        logic [31:0] rdata;
        logic [CNT_W-1:0] cnt;
        logic [1:0] cycles;
        logic cond_true;
        logic [FILE_W-1:0] wacc;
        logic [BANK_W-1:0] bank;
        logic [NUM_FLAGS-1:0] flags;
        logic [FILE_W-1:0] prod_hi;
        logic [FILE_W-1:0] prod_lo;
        logic [TPTR_W-1:0] tptr;
        logic [FILE_W-1:0] tlat;
        logic [FILE_W-1:0] opnd;
        logic [INSN_W-1:0] first;
        logic [INSN_W-1:0] second;
        logic pend;
        logic [FILE_W-1:0] sh_wacc;
        logic [NUM_FLAGS-1:0] sh_flags;
        logic [BANK_W-1:0] sh_bank;
    } ofd_regs_s;

    ofd_regs_s state_reg;
    ofd_regs_s state_next;
    ofd_fields_s live_f;
    ofd_fields_s held_f;

    // Live word is decoded as it arrives; held word feeds the readouts
    ofd_field_extract u_live (
        .insn_i(avs_writedata_i[INSN_W-1:0]),
        .fields_o(live_f)
    );

    ofd_field_extract u_held (
        .insn_i(state_reg.first),
        .fields_o(held_f)
    );

    function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] be);
        logic [31:0] m;
        m = '0;
        for (int i = 0; i < 4; i++) begin
            m[i*8 +: 8] = {8{be[i]}};
        end
        return (old_v & ~m) | (new_v & m);
    endfunction : be_merge

    logic [LONG_W-1:0] eff_addr;
    logic [TPTR_W-1:0] target;
    logic [LIT20_W-1:0] lit_val;
    logic [31:0] rd_mux;
    logic [31:0] wr_val;
    logic [8:0] sum9;
    logic [4:0] hsum;
    logic [7:0] add_res;
    logic [15:0] prod;
    logic [FILE_W-1:0] mul_b;
    logic [1:0] ncyc;
    logic [LONG_W-1:0] second_low;

    always_comb begin
        second_low = state_reg.second[LONG_W-1:0];
        // Access bank bypasses the bank register entirely
        if (held_f.acc_bank) begin
            eff_addr = {ACCESS_BANK, held_f.file_addr};
        end else begin
            eff_addr = {state_reg.bank, held_f.file_addr};
        end
        if (held_f.is_rel11) begin
            target = TPTR_W'($signed(held_f.rel11));
        end else if (held_f.is_rel8) begin
            target = TPTR_W'($signed(held_f.lo8));
        end else begin
            target = TPTR_W'({second_low, held_f.lo8});
        end
        // Literal width follows the format of the held word
        if (held_f.lfsr) begin
            lit_val = LIT20_W'({held_f.file_addr[LFSR_HI_W-1:0],
                                state_reg.second[FILE_W-1:0]});
        end else if (held_f.dword_first) begin
            lit_val = {second_low, held_f.lo8};
        end else begin
            lit_val = LIT20_W'(held_f.lo8);
        end
    end

    always_comb begin
        wr_val = '0;
        unique case (avs_address_i)
            OFS_INSN: rd_mux = 32'(state_reg.first);
            OFS_CTRL: rd_mux = 32'(state_reg.cond_true);
            OFS_WACC: rd_mux = 32'(state_reg.wacc);
            OFS_BANK: rd_mux = 32'(state_reg.bank);
            OFS_FLAGS: rd_mux = 32'(state_reg.flags);
            OFS_PROD: rd_mux = 32'({state_reg.prod_hi, state_reg.prod_lo});
            OFS_TPTR: rd_mux = 32'(state_reg.tptr);
            OFS_TLAT: rd_mux = 32'(state_reg.tlat);
            OFS_OPND: rd_mux = 32'(state_reg.opnd);
            OFS_ADDR: rd_mux = 32'({state_reg.pend, held_f.fast, held_f.step,
                                    held_f.ptr_sel, held_f.dest_file,
                                    held_f.bit_idx, eff_addr});
            OFS_LIT: rd_mux = 32'(lit_val);
            OFS_TARGET: rd_mux = {(held_f.is_rel11 | held_f.is_rel8),
                                  10'h000, target};
            // Destination is the low 12 bits of any held second word, move or not; top tag is dropped
            OFS_MOVE: rd_mux = 32'({second_low, held_f.src12});
            OFS_INDEX: rd_mux = 32'({state_reg.second[ZOFS_W-1:0],
                                     1'b0, held_f.zofs});
            OFS_CYCLES: rd_mux = 32'(state_reg.cycles);
            default: rd_mux = '0;
        endcase
        wr_val = be_merge(rd_mux, avs_writedata_i, avs_byteenable_i);
    end

    always_comb begin
        mul_b = live_f.mul_l ? live_f.lo8 : state_reg.opnd;
        prod = 16'(state_reg.wacc) * 16'(mul_b);
        sum9 = {1'b0, state_reg.wacc} + {1'b0, live_f.lo8};
        hsum = {1'b0, state_reg.wacc[3:0]} + {1'b0, live_f.lo8[3:0]};
        add_res = sum9[7:0];
        // Extra cycle only when a skip is taken or the counter moves
        if ((live_f.skip || live_f.cond_br) && state_reg.cond_true) begin
            ncyc = 2'd2;
        end else if (live_f.pc_chg) begin
            ncyc = 2'd2;
        end else begin
            ncyc = 2'd1;
        end
    end

    always_comb begin
        state_next = state_reg;
        state_next.wait_r = 1'b1;
        // Read data stand only in the answer cycle
        state_next.rdata = '0;
        unique case (state_reg.state)
            ST_IDLE: begin
                // Wait low lasts one cycle, then the held request is not retaken
                if ((avs_read_i || avs_write_i) && state_reg.wait_r) begin
                    if (avs_write_i && avs_address_i == OFS_INSN) begin
                        state_next.state = ST_EXEC;
                        if (state_reg.pend && live_f.is_second) begin
                            state_next.second = avs_writedata_i[INSN_W-1:0];
                            state_next.pend = 1'b0;
                            state_next.cycles = 2'd1;
                            if (held_f.is_call && held_f.fast) begin
                                state_next.sh_wacc = state_reg.wacc;
                                state_next.sh_flags = state_reg.flags;
                                state_next.sh_bank = state_reg.bank;
                            end
                        end else begin
                            state_next.first = avs_writedata_i[INSN_W-1:0];
                            state_next.second = '0;
                            state_next.pend = live_f.dword_first;
                            state_next.cycles = ncyc;
                            // A lone second word falls through every action
                            if (live_f.movlw) begin
                                state_next.wacc = live_f.lo8;
                            end
                            if (live_f.addlw) begin
                                state_next.wacc = add_res;
                                state_next.flags[FLG_C] = sum9[8];
                                state_next.flags[FLG_DC] = hsum[4];
                                state_next.flags[FLG_Z] = (add_res == 8'h00);
                                state_next.flags[FLG_N] = add_res[7];
                                state_next.flags[FLG_OV] =
                                    (state_reg.wacc[7] == live_f.lo8[7]) &&
                                    (add_res[7] != state_reg.wacc[7]);
                            end
                            if (live_f.mul_l || live_f.mul_f) begin
                                state_next.prod_hi = prod[15:8];
                                state_next.prod_lo = prod[7:0];
                            end
                            if (live_f.is_tbl) begin
                                unique case (live_f.step)
                                    STEP_NONE: state_next.tptr = state_reg.tptr;
                                    STEP_POST_INC: state_next.tptr = state_reg.tptr + 1'b1;
                                    STEP_POST_DEC: state_next.tptr = state_reg.tptr - 1'b1;
                                    STEP_PRE_INC: state_next.tptr = state_reg.tptr + 1'b1;
                                endcase
                                // Program byte stand-in passes through the latch
                                if (!live_f.tbl_wr) begin
                                    state_next.tlat = state_reg.opnd;
                                end
                            end
                            if (live_f.is_ret && live_f.fast) begin
                                state_next.wacc = state_reg.sh_wacc;
                                state_next.flags = state_reg.sh_flags;
                                state_next.bank = state_reg.sh_bank;
                            end
                        end
                        // One countdown over all cycles keeps the cycle readback intact
                        state_next.cnt = CNT_W'(OSC_PER_ICYC * int'(state_next.cycles) - 1);
                    end else begin
                        state_next.wait_r = 1'b0;
                        state_next.rdata = avs_read_i ? rd_mux : '0;
                        if (avs_write_i) begin
                            unique case (avs_address_i)
                                OFS_CTRL: state_next.cond_true = wr_val[CTRL_COND_POS];
                                OFS_WACC: state_next.wacc = wr_val[FILE_W-1:0];
                                OFS_BANK: state_next.bank = wr_val[BANK_W-1:0];
                                OFS_FLAGS: state_next.flags = wr_val[NUM_FLAGS-1:0];
                                OFS_TPTR: state_next.tptr = wr_val[TPTR_W-1:0];
                                OFS_TLAT: state_next.tlat = wr_val[FILE_W-1:0];
                                OFS_OPND: state_next.opnd = wr_val[FILE_W-1:0];
                                default: state_next.opnd = state_reg.opnd;
                            endcase
                        end
                    end
                end
            end
            ST_EXEC: begin
                // Answer only after all instruction cycles have elapsed
                if (state_reg.cnt != '0) begin
                    state_next.cnt = state_reg.cnt - 1'b1;
                end else begin
                    state_next.state = ST_IDLE;
                    state_next.wait_r = 1'b0;
                end
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state_reg <= '{state: ST_IDLE, wait_r: 1'b1, cycles: 2'd1, default: '0};
        end else begin
            state_reg <= state_next;
        end
    end

    assign avs_readdata_o = state_reg.rdata;
    assign avs_waitrequest_o = state_reg.wait_r;

endmodule : ofd_decoder

`default_nettype wire

//--- design/ofd_field_extract.sv
`timescale 1ns/1ps
`default_nettype none

module ofd_field_extract
    import ofd_pkg::*;
(
    input wire logic [INSN_W-1:0] insn_i,
    output ofd_fields_s fields_o
);

    always_comb begin
        fields_o = '0;
        fields_o.acc_bank = ~insn_i[A_POS];
        fields_o.dest_file = insn_i[D_POS];
        fields_o.bit_idx = insn_i[BIT_LSB +: BIT_W];
        fields_o.file_addr = insn_i[FILE_W-1:0];
        fields_o.ptr_sel = insn_i[PTR_LSB +: PTR_W];
        fields_o.src12 = insn_i[LONG_W-1:0];
        fields_o.lo8 = insn_i[FILE_W-1:0];
        fields_o.rel11 = insn_i[REL11_W-1:0];
        fields_o.step = ofd_step_e'(insn_i[1:0]);
        fields_o.zofs = insn_i[ZOFS_W-1:0];
        fields_o.tbl_wr = insn_i[TBL_WR_POS];
        // Wildcard match so don't-care bits never change the class
        casez (insn_i)
            PAT_SECOND: fields_o.is_second = 1'b1;
            PAT_MOVFF: fields_o.dword_first = 1'b1;
            PAT_CALL: begin
                fields_o.dword_first = 1'b1;
                fields_o.is_call = 1'b1;
                fields_o.fast = insn_i[CALL_FAST_POS];
            end
            PAT_LFSR: begin
                fields_o.dword_first = 1'b1;
                fields_o.lfsr = 1'b1;
            end
            PAT_GOTO: fields_o.dword_first = 1'b1;
            PAT_MOVSX: begin
                fields_o.dword_first = 1'b1;
                fields_o.ix_move = 1'b1;
            end
            PAT_BCOND: begin
                fields_o.cond_br = 1'b1;
                fields_o.is_rel8 = 1'b1;
            end
            PAT_BREL11: begin
                fields_o.pc_chg = 1'b1;
                fields_o.is_rel11 = 1'b1;
            end
            PAT_TBL: fields_o.is_tbl = 1'b1;
            PAT_RET: begin
                fields_o.pc_chg = 1'b1;
                fields_o.is_ret = 1'b1;
                fields_o.fast = insn_i[RET_FAST_POS];
            end
            PAT_MOVLW: fields_o.movlw = 1'b1;
            PAT_ADDLW: fields_o.addlw = 1'b1;
            PAT_MULLW: fields_o.mul_l = 1'b1;
            PAT_MULWF: fields_o.mul_f = 1'b1;
            PAT_CPSKIP, PAT_DECSZ, PAT_INCSZ, PAT_SNZ, PAT_BTST: fields_o.skip = 1'b1;
            default: fields_o.skip = 1'b0;
        endcase
    end

endmodule : ofd_field_extract

`default_nettype wire

//--- design/ofd_pkg.sv
package ofd_pkg;

    // Register byte offsets
    localparam int ADDR_W = 6;
    localparam logic [ADDR_W-1:0] OFS_INSN = 6'h00;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 6'h04;
    localparam logic [ADDR_W-1:0] OFS_WACC = 6'h08;
    localparam logic [ADDR_W-1:0] OFS_BANK = 6'h0C;
    localparam logic [ADDR_W-1:0] OFS_FLAGS = 6'h10;
    localparam logic [ADDR_W-1:0] OFS_PROD = 6'h14;
    localparam logic [ADDR_W-1:0] OFS_TPTR = 6'h18;
    localparam logic [ADDR_W-1:0] OFS_TLAT = 6'h1C;
    localparam logic [ADDR_W-1:0] OFS_OPND = 6'h20;
    localparam logic [ADDR_W-1:0] OFS_ADDR = 6'h24;
    localparam logic [ADDR_W-1:0] OFS_LIT = 6'h28;
    localparam logic [ADDR_W-1:0] OFS_TARGET = 6'h2C;
    localparam logic [ADDR_W-1:0] OFS_MOVE = 6'h30;
    localparam logic [ADDR_W-1:0] OFS_INDEX = 6'h34;
    localparam logic [ADDR_W-1:0] OFS_CYCLES = 6'h38;

    // Widths
    localparam int INSN_W = 16;
    localparam int FILE_W = 8;
    localparam int LONG_W = 12;
    localparam int LIT20_W = 20;
    localparam int TPTR_W = 21;
    localparam int ZOFS_W = 7;
    localparam int BANK_W = 4;
    localparam int BIT_W = 3;
    localparam int PTR_W = 2;
    localparam int REL11_W = 11;

    // Field positions inside an instruction word
    localparam int D_POS = 9;
    localparam int A_POS = 8;
    localparam int BIT_LSB = 9;
    localparam int PTR_LSB = 4;
    localparam int CALL_FAST_POS = 8;
    localparam int RET_FAST_POS = 0;
    localparam int LFSR_HI_W = 4;
    localparam int TAG_LSB = 12;
    localparam logic [3:0] SECOND_TAG = 4'hF;

    // Flag bit positions
    localparam int NUM_FLAGS = 5;
    localparam int FLG_C = 0;
    localparam int FLG_DC = 1;
    localparam int FLG_Z = 2;
    localparam int FLG_OV = 3;
    localparam int FLG_N = 4;

    localparam int CTRL_COND_POS = 0;
    localparam logic [BANK_W-1:0] ACCESS_BANK = 4'h0;
    localparam int OSC_PER_ICYC = 4;
    localparam int ICYC_MAX = 2;
    localparam int CNT_W = 4;
    localparam int TARGET_REL_POS = 31;

    // Opcode patterns; don't-care bits stay wildcards
    localparam logic [15:0] PAT_SECOND = 16'b1111_????_????_????;
    localparam logic [15:0] PAT_MOVFF = 16'b1100_????_????_????;
    localparam logic [15:0] PAT_CALL = 16'b1110_110?_????_????;
    localparam logic [15:0] PAT_LFSR = 16'b1110_1110_00??_????;
    localparam logic [15:0] PAT_GOTO = 16'b1110_1111_????_????;
    localparam logic [15:0] PAT_MOVSX = 16'b1110_1011_????_????;
    localparam logic [15:0] PAT_BCOND = 16'b1110_0???_????_????;
    localparam logic [15:0] PAT_BREL11 = 16'b1101_????_????_????;
    localparam logic [15:0] PAT_TBL = 16'b0000_0000_0000_1???;
    localparam logic [15:0] PAT_RET = 16'b0000_0000_0001_00??;
    localparam logic [15:0] PAT_MOVLW = 16'b0000_1110_????_????;
    localparam logic [15:0] PAT_ADDLW = 16'b0000_1111_????_????;
    localparam logic [15:0] PAT_MULLW = 16'b0000_1101_????_????;
    localparam logic [15:0] PAT_MULWF = 16'b0000_001?_????_????;
    localparam logic [15:0] PAT_CPSKIP = 16'b0110_0???_????_????;
    localparam logic [15:0] PAT_DECSZ = 16'b0010_11??_????_????;
    localparam logic [15:0] PAT_INCSZ = 16'b0011_11??_????_????;
    localparam logic [15:0] PAT_SNZ = 16'b0100_1???_????_????;
    localparam logic [15:0] PAT_BTST = 16'b101?_????_????_????;
    localparam int TBL_WR_POS = 2;
    localparam int MOVSS_POS = 7;

    typedef enum logic [1:0] {
        STEP_NONE = 2'h0,
        STEP_POST_INC = 2'h1,
        STEP_POST_DEC = 2'h2,
        STEP_PRE_INC = 2'h3
    } ofd_step_e;

    typedef struct packed {
        logic acc_bank;
        logic dest_file;
        logic [BIT_W-1:0] bit_idx;
        logic [FILE_W-1:0] file_addr;
        logic [PTR_W-1:0] ptr_sel;
        logic [LONG_W-1:0] src12;
        logic [FILE_W-1:0] lo8;
        logic [REL11_W-1:0] rel11;
        logic fast;
        ofd_step_e step;
        logic [ZOFS_W-1:0] zofs;
        logic is_second;
        logic dword_first;
        logic is_tbl;
        logic tbl_wr;
        logic skip;
        logic pc_chg;
        logic cond_br;
        logic is_rel11;
        logic is_rel8;
        logic mul_f;
        logic mul_l;
        logic movlw;
        logic addlw;
        logic is_call;
        logic is_ret;
        logic lfsr;
        logic ix_move;
    } ofd_fields_s;

endpackage : ofd_pkg

//--- tb/ofd_decoder_props.sv
`timescale 1ns/1ps
`default_nettype none
module ofd_decoder_props
    import ofd_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    wire logic ans = avs_read_i && !avs_waitrequest_o;
    wire logic ins = avs_write_i && avs_address_i == OFS_INSN;
    a_answer_single: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("answer held");
    a_idle_zero: assert property (avs_waitrequest_o |-> avs_readdata_o == 32'h0)
        else $error("read data not zero");
    a_answer_held: assert property (!avs_waitrequest_o |-> avs_read_i || avs_write_i)
        else $error("answer without request");
    a_read_latency: assert property ($rose(avs_read_i) |=> !avs_waitrequest_o)
        else $error("read answer late");
    a_insn_min: assert property ($rose(avs_write_i) && ins |=> avs_waitrequest_o [*4])
        else $error("instruction cycle short");
    a_insn_max: assert property ($rose(avs_write_i) && ins |-> ##[5:9] !avs_waitrequest_o)
        else $error("instruction too long");
    a_flags_width: assert property (ans && avs_address_i == OFS_FLAGS |-> avs_readdata_o[31:5] == 0)
        else $error("flags wide");
    a_tptr_width: assert property (ans && avs_address_i == OFS_TPTR |-> avs_readdata_o[31:21] == 0)
        else $error("pointer wide");
    a_latch_width: assert property (ans && avs_address_i == OFS_TLAT |-> avs_readdata_o[31:8] == 0)
        else $error("latch wide");
    a_index_width: assert property (ans && avs_address_i == OFS_INDEX |-> avs_readdata_o[31:15] == 0 && !avs_readdata_o[7])
        else $error("offset wide");
    cover property (ans && avs_address_i == OFS_FLAGS);
    cover property ($rose(avs_write_i) && ins);
    cover property (ans && avs_address_i == OFS_MOVE);
endmodule : ofd_decoder_props
bind ofd_decoder ofd_decoder_props u_props (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o));
`default_nettype wire

//--- tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import ofd_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, wt;
    logic [5:0] adr = 6'h00;
    logic [31:0] wd = 32'h0, rdat, q;
    int err_total = 0, n_checks = 0;
    ofd_decoder uut (.clk_i(clk), .rst_n_i(rst_n), .avs_address_i(adr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hF),
        .avs_readdata_o(rdat), .avs_waitrequest_o(wt));
    initial forever #50 clk = ~clk;
    task automatic final_report;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : final_report
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        rd <= !w; wr <= w; adr <= a; wd <= d;
        do begin @(posedge clk); n++; end while (wt !== 1'b0 && n < 40);
        q = rdat;
        rd <= 1'b0; wr <= 1'b0;
        if (n >= 40) begin err_total++; $display("[ERR] %0t bus timeout", $time); final_report(); end
    endtask : bus
    task automatic x(input logic [15:0] i); bus(1'b1, OFS_INSN, {16'h0, i}); endtask : x
    task automatic w(input logic [5:0] a, input logic [31:0] d); bus(1'b1, a, d); endtask : w
    task automatic rm(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        n_checks++;
        if ((q & m) !== e) begin err_total++; $display("[ERR] %0t got %h exp %h", $time, q, e); end
    endtask : rm
    task automatic t_reset;
        rm(OFS_FLAGS, 32'hFFFFFFFF, 32'h0);
        rm(OFS_CYCLES, 32'hFFFFFFFF, 32'h1);
        w(OFS_PROD, 32'h1234);
        rm(OFS_PROD, 32'hFFFFFFFF, 32'h0);
        rm(6'h3C, 32'hFFFFFFFF, 32'h0);
        $display("reset test done");
    endtask : t_reset
    task automatic t_bank;
        w(OFS_BANK, 32'h5);
        x(16'h5012); rm(OFS_ADDR, 32'h8FFF, 32'h0012);
        x(16'h5112); rm(OFS_ADDR, 32'h8FFF, 32'h0512);
        x(16'h5212); rm(OFS_ADDR, 32'h8FFF, 32'h8012);
        for (int b = 0; b < 8; b++) begin
            x({4'h8, b[2:0], 1'b1, 8'h34}); rm(OFS_ADDR, 32'h7000, {17'h0, b[2:0], 12'h0});
        end
        $display("field test done");
    endtask : t_bank
    task automatic t_alu;
        x(16'h0E80); rm(OFS_WACC, 32'hFF, 32'h80);
        x(16'h0F80); rm(OFS_FLAGS, 32'h1F, 32'h0D);
        x(16'h0E80); x(16'h0D04); rm(OFS_PROD, 32'hFFFF, 32'h0200);
        rm(OFS_LIT, 32'hFFFFF, 32'h4);
        $display("alu test done");
    endtask : t_alu
    task automatic t_dword;
        x(16'hC123); rm(OFS_ADDR, 32'h200000, 32'h200000);
        x(16'hF456); rm(OFS_MOVE, 32'hFFFFFF, 32'h456123);
        x(16'hF0FF); rm(OFS_WACC, 32'hFF, 32'h80);
        x(16'hEE1A); x(16'hF0BC); rm(OFS_LIT, 32'hFFFFF, 32'hABC);
        rm(OFS_ADDR, 32'h30000, 32'h10000);
        x(16'hEBA5); x(16'hF013); rm(OFS_INDEX, 32'h7F7F, 32'h1325);
        $display("double word test done");
    endtask : t_dword
    task automatic t_tbl;
        logic [20:0] e [4] = '{21'h100, 21'h101, 21'h0FF, 21'h101};
        w(OFS_OPND, 32'h5A);
        for (int m = 0; m < 4; m++) begin
            w(OFS_TPTR, 32'h100); x({14'h2, m[1:0]});
            rm(OFS_TPTR, 32'h1FFFFF, {11'h0, e[m]});
        end
        rm(OFS_TLAT, 32'hFF, 32'h5A);
        w(OFS_TPTR, 32'hFFFFFFFF); rm(OFS_TPTR, 32'hFFFFFFFF, 32'h1FFFFF);
        $display("table test done");
    endtask : t_tbl
    task automatic t_flow;
        x(16'hD7FF); rm(OFS_TARGET, 32'hFFFFFFFF, 32'h801FFFFF);
        rm(OFS_CYCLES, 32'hF, 32'h2);
        x(16'hEF12); x(16'hF345); rm(OFS_TARGET, 32'hFFFFFFFF, 32'h00034512);
        w(OFS_CTRL, 32'h0); x(16'hE2FE); rm(OFS_CYCLES, 32'hF, 32'h1);
        w(OFS_CTRL, 32'h1); x(16'hE2FE); rm(OFS_CYCLES, 32'hF, 32'h2);
        w(OFS_WACC, 32'h11); x(16'hED00); x(16'hF000);
        rm(OFS_ADDR, 32'h100000, 32'h100000);
        w(OFS_WACC, 32'h22); x(16'h0013); rm(OFS_WACC, 32'hFF, 32'h11);
        w(OFS_WACC, 32'h33); x(16'h0012); rm(OFS_WACC, 32'hFF, 32'h33);
        $display("flow test done");
    endtask : t_flow
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        t_reset(); t_bank(); t_alu(); t_dword(); t_tbl(); t_flow();
        final_report();
    end
endmodule : tb_top
`default_nettype wire
